// *** ccr_pkg.sv ***
// Purpose: Shared constants and carrier types for the core control register block.
// Assumes: 32-bit AXI4-Lite data, one register word per aligned address.
// Notes:   Field positions follow the 16-bit core control word layout.
package ccr_pkg;
   localparam logic [3:0]  CCR_ADDR_W          = 4'h4;
   localparam logic [3:0]  CCR_CORE_CONTROL    = 4'h0;
   localparam logic [3:0]  CCR_LOOP_STATUS     = 4'h4;
   localparam int          CCR_MULT_SIGN_BIT   = 12;
   localparam int          CCR_LOOP_TERM_BIT   = 11;
   localparam int          CCR_DEPTH_HI        = 10;
   localparam int          CCR_DEPTH_LO        = 8;
   localparam int          CCR_ACC_A_SAT_BIT   = 7;
   localparam int          CCR_ACC_B_SAT_BIT   = 6;
   localparam int          CCR_DW_SAT_BIT      = 5;
   localparam int          CCR_SAT_WIDTH_BIT   = 4;
   localparam int          CCR_PRIO_TOP_BIT    = 3;
   localparam int          CCR_PSV_BIT         = 2;
   localparam int          CCR_ROUND_BIT       = 1;
   localparam int          CCR_MULT_FMT_BIT    = 0;
   localparam logic [2:0]  CCR_DEPTH_MAX       = 3'h7;
   localparam logic [2:0]  CCR_DEPTH_ONE       = 3'h1;
   localparam logic [3:0]  CCR_PRIO_SEVEN      = 4'h7;
   localparam logic [15:0] CCR_RESET_VALUE     = 16'h0020;
   localparam logic [15:0] CCR_WRITE_MASK      = 16'h10FF;
   localparam logic [1:0]  CCR_RESP_OKAY       = 2'h0;
   localparam logic [1:0]  CCR_RESP_SLVERR     = 2'h2;

   typedef struct packed {
      logic mult_sign_select;
      logic acc_a_sat_en;
      logic acc_b_sat_en;
      logic data_write_sat_en;
      logic sat_width_select;
      logic prog_space_window_en;
      logic rounding_select;
      logic mult_format_select;
   } ccr_cfg_t;

   typedef struct packed {
      logic loop_enter;
      logic loop_exit;
   } ccr_loop_ev_t;
endpackage

// *** ccr_core_control.sv ***
// Purpose: Core control register with loop-depth tracking, AXI4-Lite slave.
// Assumes: Loop enter/exit pulses come from the sequencer on clk_i; one clock.
// Notes:   Operation
// Operation
// - Bit 11 always reads as zero.
// - Bits 10 to 8 report the number of active hardware loops, zero to seven.
// - Bit 7 enables saturation of results written to accumulator A.
// - Bit 6 enables saturation of results written to accumulator B.
// - Bit 5 enables saturation of engine writes to data memory.
// - Bit 4 picks the 9.31 limit when one and the 1.31 limit when zero.
// - Bit 3 reads one when the interrupt priority level is above seven.
// - The full priority level is bit 3 placed above status word bits 7 to 5.
// - Bit 2 makes a program memory window visible in data space.
// - Bit 1 selects conventional or convergent rounding.
// - Bit 0 selects fractional or integer multiplies.
// - Bit 12 selects unsigned or signed multiplies.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module ccr_core_control (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic [3:0]            s_axi_awaddr_i,
   input  wire logic                  s_axi_awvalid_i,
   output logic                       s_axi_awready_o,
   input  wire logic [31:0]           s_axi_wdata_i,
   input  wire logic [3:0]            s_axi_wstrb_i,
   input  wire logic                  s_axi_wvalid_i,
   output logic                       s_axi_wready_o,
   output logic [1:0]                 s_axi_bresp_o,
   output logic                       s_axi_bvalid_o,
   input  wire logic                  s_axi_bready_i,
   input  wire logic [3:0]            s_axi_araddr_i,
   input  wire logic                  s_axi_arvalid_i,
   output logic                       s_axi_arready_o,
   output logic [31:0]                s_axi_rdata_o,
   output logic [1:0]                 s_axi_rresp_o,
   output logic                       s_axi_rvalid_o,
   input  wire logic                  s_axi_rready_i,
   input  wire ccr_pkg::ccr_loop_ev_t loop_ev_i,
   input  wire logic [2:0]            priority_level_low_i,
   input  wire logic                  priority_level_top_set_i,
   input  wire logic [3:0]            priority_level_new_i,
   output ccr_pkg::ccr_cfg_t          cfg_o,
   output logic                       loop_terminate_request_o,
   output logic [2:0]                 loop_nest_depth_o,
   output logic [3:0]                 priority_level_o
);
   import ccr_pkg::*;

   logic        aw_held;
   logic        w_held;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        prio_top;
   logic [2:0]  depth;
   logic        wr_fire;
   logic        wr_hit;
   logic [15:0] cur_word;
   logic [15:0] next_word;

   assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;
   assign wr_hit  = wr_fire && (aw_addr == CCR_CORE_CONTROL);

   // Loop-terminate reads as zero; depth and priority top are live status.
   always_comb begin
      cur_word                    = 16'h0000;
      cur_word[CCR_MULT_SIGN_BIT] = cfg_o.mult_sign_select;
      cur_word[CCR_LOOP_TERM_BIT] = 1'b0;
      cur_word[CCR_DEPTH_HI:CCR_DEPTH_LO] = depth;
      cur_word[CCR_ACC_A_SAT_BIT] = cfg_o.acc_a_sat_en;
      cur_word[CCR_ACC_B_SAT_BIT] = cfg_o.acc_b_sat_en;
      cur_word[CCR_DW_SAT_BIT]    = cfg_o.data_write_sat_en;
      cur_word[CCR_SAT_WIDTH_BIT] = cfg_o.sat_width_select;
      cur_word[CCR_PRIO_TOP_BIT]  = prio_top;
      cur_word[CCR_PSV_BIT]       = cfg_o.prog_space_window_en;
      cur_word[CCR_ROUND_BIT]     = cfg_o.rounding_select;
      cur_word[CCR_MULT_FMT_BIT]  = cfg_o.mult_format_select;
      next_word = cur_word;
      if (w_strb[0]) begin
         next_word[7:0] = w_data[7:0];
      end
      if (w_strb[1]) begin
         next_word[15:8] = w_data[15:8];
      end
   end

   // Address and data are captured independently, so either may come first.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 4'h0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
      end else begin
         s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o)
                            && !s_axi_bvalid_o;
         s_axi_wready_o  <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o)
                            && !s_axi_bvalid_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= CCR_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= (aw_addr == CCR_CORE_CONTROL || aw_addr == CCR_LOOP_STATUS)
                           ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // Configuration bits steer the arithmetic engine and data-space mapping.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_o.mult_sign_select     <= CCR_RESET_VALUE[CCR_MULT_SIGN_BIT];
         cfg_o.acc_a_sat_en         <= CCR_RESET_VALUE[CCR_ACC_A_SAT_BIT];
         cfg_o.acc_b_sat_en         <= CCR_RESET_VALUE[CCR_ACC_B_SAT_BIT];
         cfg_o.data_write_sat_en    <= CCR_RESET_VALUE[CCR_DW_SAT_BIT];
         cfg_o.sat_width_select     <= CCR_RESET_VALUE[CCR_SAT_WIDTH_BIT];
         cfg_o.prog_space_window_en <= CCR_RESET_VALUE[CCR_PSV_BIT];
         cfg_o.rounding_select      <= CCR_RESET_VALUE[CCR_ROUND_BIT];
         cfg_o.mult_format_select   <= CCR_RESET_VALUE[CCR_MULT_FMT_BIT];
      end else if (wr_hit) begin
         cfg_o.mult_sign_select     <= next_word[CCR_MULT_SIGN_BIT];
         cfg_o.acc_a_sat_en         <= next_word[CCR_ACC_A_SAT_BIT];
         cfg_o.acc_b_sat_en         <= next_word[CCR_ACC_B_SAT_BIT];
         cfg_o.data_write_sat_en    <= next_word[CCR_DW_SAT_BIT];
         cfg_o.sat_width_select     <= next_word[CCR_SAT_WIDTH_BIT];
         cfg_o.prog_space_window_en <= next_word[CCR_PSV_BIT];
         cfg_o.rounding_select      <= next_word[CCR_ROUND_BIT];
         cfg_o.mult_format_select   <= next_word[CCR_MULT_FMT_BIT];
      end
   end

   // The request is a one-cycle pulse; the sequencer ends the loop at pass end.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_terminate_request_o <= 1'b0;
      end else begin
         loop_terminate_request_o <= wr_hit && w_strb[1]
                                     && w_data[CCR_LOOP_TERM_BIT];
      end
   end

   // Depth saturates at both ends so a stray event cannot wrap the count.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         depth <= 3'h0;
      end else if (loop_ev_i.loop_enter && !loop_ev_i.loop_exit
                   && depth != CCR_DEPTH_MAX) begin
         depth <= depth + CCR_DEPTH_ONE;
      end else if (loop_ev_i.loop_exit && !loop_ev_i.loop_enter && depth != 3'h0) begin
         depth <= depth - CCR_DEPTH_ONE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_nest_depth_o <= 3'h0;
      end else begin
         loop_nest_depth_o <= depth;
      end
   end

   // Interrupt logic owns the top priority bit; software cannot change it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prio_top <= 1'b0;
      end else if (priority_level_top_set_i) begin
         prio_top <= priority_level_new_i > CCR_PRIO_SEVEN;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         priority_level_o <= 4'h0;
      end else begin
         priority_level_o <= {prio_top, priority_level_low_i};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= CCR_RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rresp_o   <= CCR_RESP_OKAY;
         if (s_axi_araddr_i == CCR_CORE_CONTROL) begin
            s_axi_rdata_o <= {16'h0000, cur_word};
         end else if (s_axi_araddr_i == CCR_LOOP_STATUS) begin
            s_axi_rdata_o <= {25'h0, prio_top, priority_level_low_i, depth};
         end else begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= CCR_RESP_SLVERR;
         end
      end else if (s_axi_rvalid_o) begin
         if (s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
         end
      end else begin
         s_axi_arready_o <= 1'b1;
      end
   end

   a_term_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      s_axi_rvalid_o |-> !s_axi_rdata_o[CCR_LOOP_TERM_BIT])
      else $error("Loop terminate bit read back as one.");
   a_term_pulse_once: assert property (@(posedge clk_i) disable iff (rst_i)
      loop_terminate_request_o |=> !loop_terminate_request_o)
      else $error("Loop terminate request longer than one cycle.");
   a_term_on_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_hit && w_strb[1] && w_data[CCR_LOOP_TERM_BIT] |=> loop_terminate_request_o)
      else $error("Loop terminate request not raised after write.");
   a_depth_up_one: assert property (@(posedge clk_i) disable iff (rst_i)
      loop_ev_i.loop_enter && !loop_ev_i.loop_exit && depth != CCR_DEPTH_MAX
      |=> depth == $past(depth) + CCR_DEPTH_ONE)
      else $error("Loop depth did not count up.");
   a_depth_down_one: assert property (@(posedge clk_i) disable iff (rst_i)
      loop_ev_i.loop_exit && !loop_ev_i.loop_enter && depth != 3'h0
      |=> depth == $past(depth) - CCR_DEPTH_ONE)
      else $error("Loop depth did not count down.");
   a_depth_out_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 loop_nest_depth_o == $past(depth))
      else $error("Depth output lags wrongly.");
   a_prio_top_value: assert property (@(posedge clk_i) disable iff (rst_i)
      priority_level_top_set_i |=> prio_top == ($past(priority_level_new_i) > CCR_PRIO_SEVEN))
      else $error("Priority top bit wrong.");
   a_prio_concat: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 priority_level_o == {$past(prio_top), $past(priority_level_low_i)})
      else $error("Priority level not formed from top and low bits.");
   a_sat_a_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_hit && w_strb[0] |=> cfg_o.acc_a_sat_en == $past(w_data[CCR_ACC_A_SAT_BIT]))
      else $error("Accumulator A saturation enable not stored.");
   // Each stored field follows its own bit of a core control write that strobes its byte, and nothing else.
   a_sat_b_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_hit && w_strb[0] |=> cfg_o.acc_b_sat_en == $past(w_data[CCR_ACC_B_SAT_BIT]))
      else $error("Accumulator B saturation enable not stored.");
   a_dw_sat_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_hit && w_strb[0] |=> cfg_o.data_write_sat_en == $past(w_data[CCR_DW_SAT_BIT]))
      else $error("Data write saturation enable not stored.");
   a_sat_width_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_hit && w_strb[0] |=> cfg_o.sat_width_select == $past(w_data[CCR_SAT_WIDTH_BIT]))
      else $error("Saturation width select not stored.");
   a_window_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_hit && w_strb[0] |=> cfg_o.prog_space_window_en == $past(w_data[CCR_PSV_BIT]))
      else $error("Program window enable not stored.");
   a_round_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_hit && w_strb[0] |=> cfg_o.rounding_select == $past(w_data[CCR_ROUND_BIT]))
      else $error("Rounding select not stored.");
   a_mult_fmt_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_hit && w_strb[0] |=> cfg_o.mult_format_select == $past(w_data[CCR_MULT_FMT_BIT]))
      else $error("Multiply format select not stored.");
   a_mult_sign_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_hit && w_strb[1] |=> cfg_o.mult_sign_select == $past(w_data[CCR_MULT_SIGN_BIT]))
      else $error("Multiply sign select not stored.");
   a_cfg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !wr_hit |=> $stable(cfg_o))
      else $error("Configuration changed without a write.");
   a_term_idle_low: assert property (@(posedge clk_i) disable iff (rst_i)
      !(wr_hit && w_strb[1] && w_data[CCR_LOOP_TERM_BIT]) |=> !loop_terminate_request_o)
      else $error("Loop terminate request without a write of one.");
   a_depth_both_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      loop_ev_i.loop_enter && loop_ev_i.loop_exit |=> $stable(depth))
      else $error("Loop depth moved on a simultaneous enter and exit.");
   a_depth_floor: assert property (@(posedge clk_i) disable iff (rst_i)
      loop_ev_i.loop_exit && !loop_ev_i.loop_enter && depth == 3'h0 |=> depth == 3'h0)
      else $error("Loop depth wrapped below zero.");
   a_depth_ceiling: assert property (@(posedge clk_i) disable iff (rst_i)
      loop_ev_i.loop_enter && !loop_ev_i.loop_exit && depth == CCR_DEPTH_MAX
      |=> depth == CCR_DEPTH_MAX)
      else $error("Loop depth wrapped above seven.");
   a_prio_top_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !priority_level_top_set_i |=> $stable(prio_top))
      else $error("Priority top bit changed without a load.");
endmodule

// *** ccr_seq_model.sv ***
// Purpose: Behavioural sequencer and interrupt logic driving the core control block.
// Assumes: Events are single-cycle pulses launched just after a rising clock edge.
// Notes:   The new-level bus is inverted once the load pulse ends.
//          A design that samples it late therefore sees a wrong value.
`timescale 1ns/1ps
module ccr_seq_model (
   input  wire logic             clk_i,
   output ccr_pkg::ccr_loop_ev_t loop_ev_o,
   output logic [2:0]            priority_level_low_o,
   output logic                  priority_level_top_set_o,
   output logic [3:0]            priority_level_new_o
);
   import ccr_pkg::*;
   initial begin
      loop_ev_o = '0;
      priority_level_low_o = 3'h0;
      priority_level_top_set_o = 1'b0;
      priority_level_new_o = 4'hF;
   end
   task automatic loop_step(input logic en, input logic ex);
      @(posedge clk_i);
      loop_ev_o <= '{loop_enter: en, loop_exit: ex};
      @(posedge clk_i);
      loop_ev_o <= '0;
   endtask
   task automatic set_level(input logic [3:0] lvl);
      @(posedge clk_i);
      priority_level_low_o <= lvl[2:0];
      priority_level_new_o <= lvl;
      priority_level_top_set_o <= 1'b1;
      @(posedge clk_i);
      priority_level_top_set_o <= 1'b0;
      priority_level_new_o <= ~lvl;
   endtask
endmodule

// *** test_core_dsp_control_register.sv ***
// Purpose: Self-checking bench for the core control register block.
// Assumes: AXI4-Lite master changes its signals right after rising edges.
// Notes:   A shadow copy of the writable bits predicts the core control readback.
`timescale 1ns/1ps
module test_core_dsp_control_register;
   import ccr_pkg::*;
   logic clk_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
   logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
   logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, loop_terminate_request_o;
   logic [3:0] s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i, priority_level_new_i;
   logic [3:0] priority_level_o, s, lv;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
   logic [2:0] priority_level_low_i, loop_nest_depth_o, dp, lo;
   logic [15:0] sh;
   logic priority_level_top_set_i, tp;
   ccr_loop_ev_t loop_ev_i;
   ccr_cfg_t cfg_o;
   int seed, mismatches, comparisons, pulses, xp;
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (loop_terminate_request_o === 1'b1) pulses++;
   ccr_core_control u_dut (.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
      .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
      .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
      .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
      .loop_ev_i, .priority_level_low_i, .priority_level_top_set_i, .priority_level_new_i,
      .cfg_o, .loop_terminate_request_o, .loop_nest_depth_o, .priority_level_o);
   ccr_seq_model u_seq (.clk_i, .loop_ev_o(loop_ev_i),
      .priority_level_low_o(priority_level_low_i),
      .priority_level_top_set_o(priority_level_top_set_i),
      .priority_level_new_o(priority_level_new_i));
   task automatic summarize();
      if (mismatches == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] st);
      int n;
      logic aw, w;
      @(posedge clk_i);
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= v;
      s_axi_wstrb_i <= st;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk_i);
         if (aw && s_axi_awready_o === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid_i <= 1'b0;
         end
         if (w && s_axi_wready_o === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid_i <= 1'b0;
         end
         if (s_axi_bvalid_o === 1'b1) break;
      end
      r = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
      if (n == 64) begin
         $display("mismatch at %0t: write response timed out", $time);
         mismatches++;
         summarize();
      end
   endtask
   task automatic rd(input logic [3:0] a);
      int n;
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge clk_i);
         if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
         if (s_axi_rvalid_o === 1'b1) break;
      end
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
      if (n == 64) begin
         $display("mismatch at %0t: read response timed out", $time);
         mismatches++;
         summarize();
      end
   endtask
   // Bit 3 and bits 11 to 8 are never taken from software writes.
   function automatic logic [31:0] exp_cc();
      return {16'h0000, sh & 16'h10F7} | {21'h0, dp, 8'h00} | {28'h0, tp, 3'h0};
   endfunction
   function automatic logic [31:0] exp_cfg();
      return {24'h0, sh[12], sh[7:4], sh[2:0]};
   endfunction
   task automatic check_all();
      rd(CCR_CORE_CONTROL);
      cmp(d, exp_cc());
      cmp({24'h0, cfg_o}, exp_cfg());
      rd(CCR_LOOP_STATUS);
      cmp(d, {25'h0, tp, lo, dp});
      cmp({29'h0, loop_nest_depth_o}, {29'h0, dp});
      cmp({28'h0, priority_level_o}, {28'h0, tp, lo});
   endtask
   initial begin
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i, s_axi_wdata_i} = '0;
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
      {seed, mismatches, comparisons, pulses, xp} = {32'd98, 128'd0};
      rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      {sh, dp, tp, lo} = {16'h0020, 7'h00};
      check_all();
      for (int i = 0; i < 12; i++) begin
         d = $random(seed);
         s = (i == 10) ? 4'h2 : (i == 11) ? 4'h1 : 4'h3;
         if (i == 10) d[11] = 1'b1;
         wr(CCR_CORE_CONTROL, d, s);
         cmp({30'h0, r}, {30'h0, CCR_RESP_OKAY});
         if (s[0]) sh[7:0] = d[7:0];
         if (s[1]) sh[15:8] = d[15:8];
         if (s[1] && d[11]) xp++;
         check_all();
      end
      cmp(pulses, xp);
      repeat (8) u_seq.loop_step(1'b1, 1'b0);
      dp = 3'h7;
      u_seq.loop_step(1'b1, 1'b1);
      check_all();
      repeat (3) u_seq.loop_step(1'b0, 1'b1);
      dp = 3'h4;
      check_all();
      repeat (6) u_seq.loop_step(1'b0, 1'b1);
      dp = 3'h0;
      check_all();
      for (int i = 0; i < 4; i++) begin
         lv = (i == 0) ? 4'h9 : (i == 1) ? 4'h7 : (i == 2) ? 4'h8 : 4'hF;
         u_seq.set_level(lv);
         tp = (lv > CCR_PRIO_SEVEN);
         lo = lv[2:0];
         repeat (2) @(posedge clk_i);
         check_all();
      end
      wr(4'h8, 32'hFFFFFFFF, 4'hF);
      cmp({30'h0, r}, {30'h0, CCR_RESP_SLVERR});
      rd(4'hC);
      cmp({30'h0, r}, {30'h0, CCR_RESP_SLVERR});
      cmp(d, 32'h0000_0000);
      wr(CCR_LOOP_STATUS, 32'hFFFFFFFF, 4'hF);
      cmp({30'h0, r}, {30'h0, CCR_RESP_OKAY});
      check_all();
      cmp(pulses, xp);
      summarize();
   end
endmodule
